// file: design/ccse_engine.sv
// Command interpreter for the configuration port byte stream
`timescale 1ns/1ps
`default_nettype none
module ccse_engine #(
   parameter logic [31:0] IDENTITY_CODE = ccse_pkg::IDENTITY_DEFAULT // Arbitrary
)(
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire ccse_pkg::ccse_byte_s cmd_i,
   input wire logic rd_ack_i,
   input wire logic op_busy_i,
   input wire logic op_done_i,
   input wire logic op_fail_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   output logic cfg_enable_o,
   output logic user_offline_o,
   output logic [31:0] status_o
);
   ccse_pkg::ccse_state_e state_r, state_nxt;
   logic [7:0] opcode_r, opcode_nxt;
   logic [23:0] operand_r, operand_nxt;
   logic [2:0] cnt_r, cnt_nxt;
   logic [31:0] shift_r, shift_nxt;
   logic [2:0] left_r, left_nxt;
   logic en_r, en_nxt, off_r, off_nxt, done_r, done_nxt;
   logic fail_r, fail_nxt, inval_r, inval_nxt;
   logic [31:0] status_word;

   // Status composed live so a read reflects the current busy state
   always_comb
   begin
      status_word = ccse_pkg::STATUS_RESET;
      status_word[ccse_pkg::ST_DONE_BIT] = done_r;
      status_word[ccse_pkg::ST_ENABLE_BIT] = en_r;
      status_word[ccse_pkg::ST_BUSY_BIT] = op_busy_i;
      status_word[ccse_pkg::ST_FAIL_BIT] = fail_r;
      status_word[ccse_pkg::ST_INVALID_BIT] = inval_r;
   end

   always_comb
   begin
      state_nxt = state_r;
      opcode_nxt = opcode_r;
      operand_nxt = operand_r;
      cnt_nxt = cnt_r;
      shift_nxt = shift_r;
      left_nxt = left_r;
      en_nxt = en_r;
      off_nxt = off_r;
      done_nxt = done_r;
      fail_nxt = fail_r;
      inval_nxt = inval_r;
      // Operation results; a start clears, completion wins the same cycle
      if (op_busy_i)
      begin
         done_nxt = 1'b0;
         fail_nxt = 1'b0;
      end
      if (op_done_i)
      begin
         done_nxt = !op_fail_i;
         fail_nxt = op_fail_i;
      end
      // A start byte always reframes, whatever state, so all ports match
      if (cmd_i.valid && cmd_i.start)
      begin
         opcode_nxt = cmd_i.data;
         cnt_nxt = 3'h0;
         operand_nxt = 24'h000000;
         left_nxt = 3'h0;
         state_nxt = ccse_pkg::CCSE_OPERAND;
      end
      else
      begin
         unique case (state_r)
            ccse_pkg::CCSE_IDLE:
            begin
            end
            ccse_pkg::CCSE_OPERAND:
            begin
               if (cmd_i.valid)
               begin
                  operand_nxt = {operand_r[15:0], cmd_i.data};
                  cnt_nxt = cnt_r + 3'h1;
                  if (cnt_r == ccse_pkg::OPERAND_BYTES - 3'h1)
                  begin
                     state_nxt = ccse_pkg::CCSE_SKIP;
                     unique case (opcode_r)
                        ccse_pkg::OP_READ_IDENTITY:
                        begin
                           shift_nxt = IDENTITY_CODE;
                           left_nxt = 3'h4;
                           state_nxt = ccse_pkg::CCSE_READ;
                        end
                        ccse_pkg::OP_STATUS_READ:
                        begin
                           shift_nxt = status_word;
                           left_nxt = 3'h4;
                           state_nxt = ccse_pkg::CCSE_READ;
                        end
                        ccse_pkg::OP_BUSY_CHECK:
                        begin
                           shift_nxt = 32'h00000000;
                           shift_nxt[24 + ccse_pkg::BUSY_BYTE_BIT] =
                              op_busy_i;
                           left_nxt = 3'h1;
                           state_nxt = ccse_pkg::CCSE_READ;
                        end
                        ccse_pkg::OP_ENABLE_TRANSPARENT:
                        begin
                           en_nxt = 1'b1;
                           off_nxt = 1'b0;
                        end
                        ccse_pkg::OP_ENABLE_OFFLINE:
                        begin
                           en_nxt = 1'b1;
                           off_nxt = 1'b1;
                        end
                        default:
                           inval_nxt = 1'b1;
                     endcase
                  end
               end
            end
            ccse_pkg::CCSE_READ:
            begin
               if (rd_ack_i)
               begin
                  shift_nxt = {shift_r[23:0], 8'h00};
                  left_nxt = left_r - 3'h1;
                  if (left_r == 3'h1)
                  begin
                     state_nxt = ccse_pkg::CCSE_SKIP;
                  end
               end
            end
            ccse_pkg::CCSE_SKIP:
            begin
               // Write data of other commands is absorbed here
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         state_r <= ccse_pkg::CCSE_IDLE;
         opcode_r <= 8'h00;
         operand_r <= 24'h000000;
         cnt_r <= 3'h0;
         shift_r <= 32'h00000000;
         left_r <= 3'h0;
         en_r <= 1'b0;
         off_r <= 1'b0;
         done_r <= 1'b0;
         fail_r <= 1'b0;
         inval_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         opcode_r <= opcode_nxt;
         operand_r <= operand_nxt;
         cnt_r <= cnt_nxt;
         shift_r <= shift_nxt;
         left_r <= left_nxt;
         en_r <= en_nxt;
         off_r <= off_nxt;
         done_r <= done_nxt;
         fail_r <= fail_nxt;
         inval_r <= inval_nxt;
      end
   end

   assign rd_data_o = shift_r[31:24];
   assign rd_valid_o = (state_r == ccse_pkg::CCSE_READ);
   assign cfg_enable_o = en_r;
   assign user_offline_o = off_r;
   assign status_o = status_word;

   property p_ident;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_r == ccse_pkg::CCSE_OPERAND && cmd_i.valid && !cmd_i.start
       && cnt_r == 3'h2 && opcode_r == ccse_pkg::OP_READ_IDENTITY)
      |=> rd_valid_o && rd_data_o == IDENTITY_CODE[31:24];
   endproperty
   a_ident: assert property (p_ident) else $error("identity byte wrong");

   property p_transp;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_r == ccse_pkg::CCSE_OPERAND && cmd_i.valid && !cmd_i.start
       && cnt_r == 3'h2 && opcode_r == ccse_pkg::OP_ENABLE_TRANSPARENT)
      |=> cfg_enable_o && !user_offline_o;
   endproperty
   a_transp: assert property (p_transp) else $error("transparent enable");

   property p_offl;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_r == ccse_pkg::CCSE_OPERAND && cmd_i.valid && !cmd_i.start
       && cnt_r == 3'h2 && opcode_r == ccse_pkg::OP_ENABLE_OFFLINE)
      |=> cfg_enable_o && user_offline_o;
   endproperty
   a_offl: assert property (p_offl) else $error("offline enable");

   property p_busyb;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (state_r == ccse_pkg::CCSE_OPERAND && cmd_i.valid && !cmd_i.start
       && cnt_r == 3'h2 && opcode_r == ccse_pkg::OP_BUSY_CHECK)
      |=> rd_valid_o && rd_data_o[7] == $past(op_busy_i)
          && rd_data_o[6:0] == 7'h00;
   endproperty
   a_busyb: assert property (p_busyb) else $error("busy byte wrong");

   property p_stbusy;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      status_o[ccse_pkg::ST_BUSY_BIT] == op_busy_i
      && status_o[ccse_pkg::ST_ENABLE_BIT] == cfg_enable_o
      && (status_o & 32'hEFFFCCFF) == 32'h00000000;
   endproperty
   a_stbusy: assert property (p_stbusy) else $error("status busy");

   property p_done;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      (op_done_i && !op_fail_i && !op_busy_i) ##1 !op_busy_i
      |-> status_o[8] && !status_o[12] && !status_o[13];
   endproperty
   a_done: assert property (p_done) else $error("done status");

   property p_fail;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      op_done_i && op_fail_i |=> status_o[13] && !status_o[8];
   endproperty
   a_fail: assert property (p_fail) else $error("fail status");

   property p_frame;
      @(posedge clk_sys_i) disable iff (sys_rst_i)
      cmd_i.valid && cmd_i.start |=> state_r == ccse_pkg::CCSE_OPERAND
         && cnt_r == 3'h0 && !rd_valid_o;
   endproperty
   a_frame: assert property (p_frame) else $error("frame start");

   c_ident: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      rd_valid_o && opcode_r == ccse_pkg::OP_READ_IDENTITY);
   c_stat: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      rd_valid_o && rd_ack_i && opcode_r == ccse_pkg::OP_STATUS_READ);
   c_offl: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      user_offline_o);
   // Operands are kept for visibility only; enables ignore their value
   c_enop: cover property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      state_r == ccse_pkg::CCSE_SKIP && cfg_enable_o
      && operand_r == ccse_pkg::OPERAND_ENABLE);
endmodule : ccse_engine
`default_nettype wire

// file: design/ccse_pkg.sv
// Package of constants and types for the configuration command engine
// Contract
// - Same command set and timing on every configuration port.
// - Opcode E0 with zero operands returns four identity bytes.
// - Opcode 74 with 08 00 00 enables configuration, user logic keeps running.
// - Opcode C6 with 08 00 00 enables configuration, user logic offline.
// - Opcode F0 returns one byte; bit 7 is busy.
// - Opcode 3C returns four status bytes; bit 12 busy, bit 13 fail.
// - After successful program, status shows done bit 8, busy and fail clear.
package ccse_pkg;
   localparam logic [7:0] OP_READ_IDENTITY = 8'hE0;
   localparam logic [7:0] OP_ENABLE_TRANSPARENT = 8'h74;
   localparam logic [7:0] OP_ENABLE_OFFLINE = 8'hC6;
   localparam logic [7:0] OP_BUSY_CHECK = 8'hF0;
   localparam logic [7:0] OP_STATUS_READ = 8'h3C;
   localparam logic [23:0] OPERAND_ZERO = 24'h000000;
   localparam logic [23:0] OPERAND_ENABLE = 24'h080000;
   localparam int BUSY_BYTE_BIT = 7;
   localparam int ST_DONE_BIT = 8;
   localparam int ST_ENABLE_BIT = 9;
   localparam int ST_BUSY_BIT = 12;
   localparam int ST_FAIL_BIT = 13;
   localparam int ST_INVALID_BIT = 28;
   localparam logic [31:0] STATUS_RESET = 32'h00000000;
   // Arbitrary identity value; real parts override it at the instance
   localparam logic [31:0] IDENTITY_DEFAULT = 32'h0A5A5A5A;
   localparam logic [2:0] OPERAND_BYTES = 3'h3;

   typedef enum logic [1:0]
   {
      CCSE_IDLE = 2'b00,
      CCSE_OPERAND = 2'b01,
      CCSE_READ = 2'b10,
      CCSE_SKIP = 2'b11
   } ccse_state_e;

   typedef struct packed
   {
      logic start;
      logic valid;
      logic [7:0] data;
   } ccse_byte_s;
endpackage : ccse_pkg

// file: test/ccse_host_model.sv
// Host model that frames commands and collects read bytes
`timescale 1ns/1ps
`default_nettype none
module ccse_host_model (
   input wire logic clk_i,
   input wire logic [7:0] rd_data_i,
   input wire logic rd_valid_i,
   output var ccse_pkg::ccse_byte_s cmd_o,
   output logic rd_ack_o
);
   logic [7:0] last_q;
   initial
   begin
      cmd_o = '0;
      rd_ack_o = 1'b0;
      last_q = 8'h00;
   end
   // Idle data lines show the inverse of the last byte, never a stale copy
   task automatic put(input logic st, input logic [7:0] b);
      @(posedge clk_i);
      cmd_o <= '{start: st, valid: 1'b1, data: b};
      last_q = b;
      @(posedge clk_i);
      cmd_o <= '{start: 1'b0, valid: 1'b0, data: ~last_q};
   endtask : put
   task automatic run(input logic [7:0] op, input logic [23:0] opnd,
                      input int n, output logic [31:0] w);
      int k;
      w = '0;
      put(1'b1, op);
      for (int i = 2; i >= 0; i--) put(1'b0, opnd[i*8 +: 8]);
      for (int i = 0; i < n; i++)
      begin
         k = 0;
         do
         begin
            @(posedge clk_i);
            #1;
            k++;
         end while (rd_valid_i !== 1'b1 && k < 8);
         w = {w[23:0], rd_data_i};
         @(posedge clk_i);
         rd_ack_o <= 1'b1;
         @(posedge clk_i);
         rd_ack_o <= 1'b0;
      end
      @(posedge clk_i);
      #1;
   endtask : run
endmodule : ccse_host_model
`default_nettype wire

// file: test/config_cmd_status_engine_tb.sv
// Self-checking bench for the configuration command engine
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
   begin \
      n_checks++; \
      if ((got) !== (exp)) \
      begin \
         error_cnt++; \
         $display("wrong value at %0t: %s", $time, msg); \
      end \
   end
module config_cmd_status_engine_tb;
   localparam logic [31:0] ID_CODE = 32'h1B2C3D4E; // Arbitrary value
   logic clk_sys_i, sys_rst_i, rd_ack, op_busy, op_done, op_fail;
   logic rd_valid, cfg_en, offline, m_done, m_fail, m_en, m_inv, f;
   logic [7:0] rd_data;
   logic [31:0] status, w;
   ccse_pkg::ccse_byte_s cmd;
   logic [7:0] exp_q[$];
   int error_cnt = 0;
   int n_checks = 0;
   ccse_engine #(.IDENTITY_CODE(ID_CODE)) dut_u (.clk_sys_i(clk_sys_i),
      .sys_rst_i(sys_rst_i), .cmd_i(cmd), .rd_ack_i(rd_ack),
      .op_busy_i(op_busy), .op_done_i(op_done), .op_fail_i(op_fail),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .cfg_enable_o(cfg_en),
      .user_offline_o(offline), .status_o(status));
   ccse_host_model host_u (.clk_i(clk_sys_i), .rd_data_i(rd_data),
      .rd_valid_i(rd_valid), .cmd_o(cmd), .rd_ack_o(rd_ack));
   function automatic logic [31:0] exp_status();
      return {3'b0, m_inv, 14'b0, m_fail, op_busy, 2'b0, m_en, m_done, 8'b0};
   endfunction : exp_status
   task automatic stop_test();
      if (error_cnt == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   task automatic do_rst();
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      {m_done, m_fail, m_en, m_inv} = 4'h0;
   endtask : do_rst
   // Expected bytes queue up MSB first and are matched byte by byte
   task automatic chk_read(input logic [31:0] e, input int n);
      logic [7:0] b;
      for (int i = n - 1; i >= 0; i--)
         exp_q.push_back(e[i*8 +: 8]);
      for (int i = n - 1; i >= 0; i--)
      begin
         b = exp_q.pop_front();
         `CHK(w[i*8 +: 8], b, "read byte")
      end
   endtask : chk_read
   task automatic read_status();
      host_u.run(ccse_pkg::OP_STATUS_READ, ccse_pkg::OPERAND_ZERO, 4, w);
      `CHK(w, exp_status(), "status word")
      `CHK(status, exp_status(), "status port")
      chk_read(exp_status(), 4);
   endtask : read_status
   // Program cycle: busy for a while, then a done pulse with a result
   task automatic op_cycle(input logic fl);
      @(posedge clk_sys_i);
      op_busy <= 1'b1;
      {m_done, m_fail} = 2'b00;
      repeat (3) @(posedge clk_sys_i);
      op_busy <= 1'b0;
      op_done <= 1'b1;
      op_fail <= fl;
      @(posedge clk_sys_i);
      op_done <= 1'b0;
      op_fail <= 1'b0;
      m_done = ~fl;
      m_fail = fl;
   endtask : op_cycle
   initial
   begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   initial
   begin
      #500000;
      error_cnt++;
      stop_test();
   end
   initial
   begin
      {sys_rst_i, op_busy, op_done, op_fail} = 4'h8;
      void'($urandom(32'h1759));
      do_rst();
      // Abandoned read: the next start byte has to reframe mid-read
      host_u.run(ccse_pkg::OP_READ_IDENTITY, ccse_pkg::OPERAND_ZERO, 2, w);
      `CHK(w[15:0], ID_CODE[31:16], "identity head")
      host_u.run(ccse_pkg::OP_READ_IDENTITY, ccse_pkg::OPERAND_ZERO, 4, w);
      `CHK(w, ID_CODE, "identity")
      `CHK(rd_valid, 1'b0, "read not closed")
      read_status();
      `CHK(w & 32'h00003100, 32'h0, "erased status")
      for (int j = 0; j < 5; j++)
      begin
         f = (j < 2) ? j[0] : 1'($urandom_range(1, 0));
         op_cycle(f);
         read_status();
         `CHK(w & 32'h00003100, f ? 32'h2000 : 32'h100, "masked")
      end
      for (int j = 1; j >= 0; j--)
      begin
         @(posedge clk_sys_i);
         op_busy <= j[0];
         // A new operation wipes the previous result
         if (j == 1)
            {m_done, m_fail} = 2'b00;
         host_u.run(ccse_pkg::OP_BUSY_CHECK, ccse_pkg::OPERAND_ZERO, 1, w);
         `CHK(w[7:0], {j[0], 7'h0}, "busy byte")
         read_status();
      end
      host_u.run(8'h55, 24'($urandom), 0, w);
      m_inv = 1'b1;
      read_status();
      host_u.run(ccse_pkg::OP_ENABLE_TRANSPARENT, ccse_pkg::OPERAND_ENABLE, 0, w);
      m_en = 1'b1;
      `CHK({cfg_en, offline}, 2'b10, "transparent")
      read_status();
      do_rst();
      host_u.run(ccse_pkg::OP_ENABLE_OFFLINE, ccse_pkg::OPERAND_ENABLE, 0, w);
      m_en = 1'b1;
      `CHK({cfg_en, offline}, 2'b11, "offline")
      read_status();
      stop_test();
   end
endmodule : config_cmd_status_engine_tb
`default_nettype wire
